// >>> shared/smm_stop_clock_req_n_pkg.sv
// package: states, synchroniser depth and request encodings for the
// sideband control block
// assumes: a single core clock, synchronous active-low reset
package smm_stop_clock_req_n_pkg;

  // stages of the input synchroniser
  localparam int SYNC_STAGES = 2;

  // acknowledge transaction codes toward the bus unit
  localparam logic [1:0] ACK_NONE    = 2'h0;
  localparam logic [1:0] ACK_SMM     = 2'h1;
  localparam logic [1:0] ACK_STPGNT  = 2'h2;

  // control states
  typedef enum logic [2:0] {
    ST_RUN      = 3'h0,
    ST_SAVE     = 3'h1,
    ST_SMM_ACK  = 3'h2,
    ST_SMM      = 3'h3,
    ST_SG_ACK   = 3'h4,
    ST_STPGNT   = 3'h5,
    ST_SLEEP    = 3'h6
  } ctl_state_e;

endpackage

// >>> core/sync_2ff.sv
// two-stage synchroniser for one asynchronous level
// assumes: input comes from outside the core clock domain
`timescale 1ns/100ps
`default_nettype none
module sync_2ff
  import smm_stop_clock_req_n_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // async level in, synchronous level out
  input  wire logic async_in,
  output var  logic sync_out
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] chain;
  } sync_s;

  sync_s state_ff;
  sync_s nxt_state;

  always_comb
  begin
    nxt_state       = state_ff;
    // first stage is read only by the second
    nxt_state.chain = {state_ff.chain[SYNC_STAGES-2:0], async_in};
  end

  // reset to released level (inputs are active low)
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      state_ff <= '{chain: {SYNC_STAGES{1'b1}}};
    else
      state_ff <= nxt_state;
  end

  assign sync_out = state_ff.chain[SYNC_STAGES-1];

endmodule
`default_nettype wire

// >>> core/smm_stop_clock_req_n_ctl.sv
// sideband control: system management entry and stop-grant / sleep
// assumes: request pins driven asynchronously by chipset logic; bus unit
// accepts one acknowledge request per pulse; state save takes one handshake
`timescale 1ns/100ps
`default_nettype none
module smm_stop_clock_req_n_ctl
  import smm_stop_clock_req_n_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // asynchronous sideband pins
  input  wire logic       sys_mgmt_irq_n,
  input  wire logic       stop_clock_req_n,
  input  wire logic       sleep_req_n,
  // core handshakes
  input  wire logic       save_done,
  input  wire logic       rsm_exit,
  input  wire logic       ack_done,
  // core controls
  output var  logic       save_req,
  output var  logic       sys_mgmt_mode,
  output var  logic       handler_fetch,
  output var  logic       outputs_tristate,
  // acknowledge request to bus unit
  output var  logic       ack_req,
  output var  logic [1:0] ack_code,
  // clock gating
  output var  logic       core_clk_en,
  output var  logic       bus_clk_en,
  output var  logic       irq_ctrl_clk_en,
  output var  logic       snoop_en,
  output var  logic       pll_only
);

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  logic smi_s_n;
  logic stp_s_n;
  logic slp_s_n;

  sync_2ff u_sync_smi
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (sys_mgmt_irq_n),
    .sync_out (smi_s_n)
  );

  sync_2ff u_sync_stp
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (stop_clock_req_n),
    .sync_out (stp_s_n)
  );

  sync_2ff u_sync_slp
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (sleep_req_n),
    .sync_out (slp_s_n)
  );

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    ctl_state_e st;
    logic       rst_seen;
    logic [1:0] settle;
    logic       tri_st;
    logic       smi_prev_n;
    logic       smi_pend;
    logic       save_req;
    logic       ack_req;
    logic [1:0] ack_code;
    logic       fetch;
    logic       mode;
    logic       core_en;
    logic       bus_en;
    logic       irq_en;
    logic       snoop;
    logic       pll_only;
  } ctl_s;

  localparam ctl_s CTL_RST = '{
    st: ST_RUN, rst_seen: 1'b0, settle: 2'h0, tri_st: 1'b0, smi_prev_n: 1'b1,
    smi_pend: 1'b0, save_req: 1'b0, ack_req: 1'b0, ack_code: ACK_NONE,
    fetch: 1'b0, mode: 1'b0, core_en: 1'b1, bus_en: 1'b1, irq_en: 1'b1,
    snoop: 1'b1, pll_only: 1'b0
  };

  localparam logic [1:0] SETTLE_LAST = 2'(SYNC_STAGES);

  ctl_s state_ff;
  ctl_s nxt_state;

  always_comb
  begin
    nxt_state            = state_ff;
    nxt_state.ack_req    = 1'b0;
    nxt_state.fetch      = 1'b0;
    nxt_state.smi_prev_n = smi_s_n;
    // chains leave reset at the released level; strap only once the
    // pin level seen at release has passed both stages
    if (!state_ff.rst_seen)
    begin
      if (state_ff.settle == SETTLE_LAST)
      begin
        nxt_state.rst_seen = 1'b1;
        nxt_state.tri_st   = !smi_s_n;
      end
      else
        nxt_state.settle = state_ff.settle + 2'h1;
    end
    case (state_ff.st)
      ST_RUN:
      begin
        // idle before the strap or once tristated; stop wins over irq
        if (state_ff.tri_st || !state_ff.rst_seen)
          nxt_state.st = ST_RUN;
        else if (!stp_s_n)
        begin
          nxt_state.st = ST_SG_ACK;
          nxt_state.ack_req  = 1'b1;
          nxt_state.ack_code = ACK_STPGNT;
        end
        else if (state_ff.smi_pend)
        begin
          nxt_state.st       = ST_SAVE;
          nxt_state.save_req = 1'b1;
          nxt_state.smi_pend = 1'b0;
        end
      end
      ST_SAVE:
      begin
        if (save_done)
        begin
          nxt_state.save_req = 1'b0;
          nxt_state.st       = ST_SMM_ACK;
          nxt_state.ack_req  = 1'b1;
          nxt_state.ack_code = ACK_SMM;
          nxt_state.mode     = 1'b1;
        end
      end
      ST_SMM_ACK:
      begin
        if (ack_done)
        begin
          nxt_state.st       = ST_SMM;
          nxt_state.fetch    = 1'b1;
          nxt_state.ack_code = ACK_NONE;
        end
      end
      ST_SMM:
      begin
        if (rsm_exit)
        begin
          nxt_state.st   = ST_RUN;
          nxt_state.mode = 1'b0;
        end
      end
      ST_SG_ACK:
      begin
        if (ack_done)
        begin
          nxt_state.st       = ST_STPGNT;
          nxt_state.ack_code = ACK_NONE;
          nxt_state.core_en  = 1'b0;
          nxt_state.snoop    = 1'b1;
        end
      end
      ST_STPGNT:
      begin
        if (stp_s_n)
        begin
          nxt_state.st      = ST_RUN;
          nxt_state.core_en = 1'b1;
        end
        else if (!slp_s_n)
        begin
          nxt_state.st       = ST_SLEEP;
          nxt_state.snoop    = 1'b0;
          nxt_state.pll_only = 1'b1;
          nxt_state.bus_en   = 1'b0;
          nxt_state.irq_en   = 1'b0;
        end
      end
      ST_SLEEP:
      begin
        if (slp_s_n)
        begin
          // back to stop-grant: bus side restarts, core stays gated
          nxt_state.st       = ST_STPGNT;
          nxt_state.snoop    = 1'b1;
          nxt_state.pll_only = 1'b0;
          nxt_state.bus_en   = 1'b1;
          nxt_state.irq_en   = 1'b1;
        end
      end
      default:
        nxt_state = CTL_RST;
    endcase
    // falling edge of irq latched as pending; a new edge wins over the clear
    if (state_ff.rst_seen && state_ff.smi_prev_n && !smi_s_n)
      nxt_state.smi_pend = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      state_ff <= CTL_RST;
    else
      state_ff <= nxt_state;
  end

  // --------------------------------------------------------------
  // outputs, all straight from flops
  // --------------------------------------------------------------
  assign save_req         = state_ff.save_req;
  assign sys_mgmt_mode    = state_ff.mode;
  assign handler_fetch    = state_ff.fetch;
  assign outputs_tristate = state_ff.tri_st;
  assign ack_req          = state_ff.ack_req;
  assign ack_code         = state_ff.ack_code;
  assign core_clk_en      = state_ff.core_en;
  assign bus_clk_en       = state_ff.bus_en;
  assign irq_ctrl_clk_en  = state_ff.irq_en;
  assign snoop_en         = state_ff.snoop;
  assign pll_only         = state_ff.pll_only;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_save_before_mode: assert property (
    save_req && save_done |=> sys_mgmt_mode && ack_req && ack_code == ACK_SMM)
    else $error("save completion did not enter mode with acknowledge");
  a_smm_ack_issue: assert property (
    $rose(sys_mgmt_mode) |-> ack_req && ack_code == ACK_SMM)
    else $error("mode entry without acknowledge");
  a_fetch_after_ack: assert property (
    state_ff.st == ST_SMM_ACK && ack_done |=> handler_fetch && sys_mgmt_mode)
    else $error("no handler fetch after acknowledge");
  a_tristate_strap: assert property (
    !state_ff.rst_seen && state_ff.settle == SETTLE_LAST && !smi_s_n |=> outputs_tristate)
    else $error("irq at reset release did not tristate");
  a_tristate_hold: assert property (
    outputs_tristate |-> state_ff.st == ST_RUN && !save_req && !ack_req)
    else $error("activity while tristated");
  a_stop_entry: assert property (
    state_ff.st == ST_RUN && state_ff.rst_seen && !outputs_tristate && !stp_s_n
      |=> ack_req && ack_code == ACK_STPGNT)
    else $error("stop request did not issue stop-grant acknowledge");
  a_grant_entry: assert property (
    state_ff.st == ST_SG_ACK && ack_done |=> !core_clk_en && state_ff.st == ST_STPGNT)
    else $error("stop-grant acknowledge did not gate core clocks");
  a_grant_gating: assert property (
    state_ff.st == ST_STPGNT |-> !core_clk_en && bus_clk_en && irq_ctrl_clk_en)
    else $error("stop-grant clock gating wrong");
  a_grant_snoop: assert property (
    state_ff.st == ST_STPGNT |-> snoop_en)
    else $error("snooping lost in stop-grant");
  a_resume_clocks: assert property (
    state_ff.st == ST_STPGNT && stp_s_n |=> core_clk_en && state_ff.st == ST_RUN)
    else $error("release did not ungate clocks");
  a_bus_clock_kept: assert property (
    !pll_only |-> bus_clk_en && irq_ctrl_clk_en)
    else $error("bus or irq controller clock stopped outside sleep");
  a_sleep_gate: assert property (
    $rose(pll_only) |-> $past(state_ff.st) == ST_STPGNT)
    else $error("sleep entered outside stop-grant");
  a_sleep_clocks: assert property (
    pll_only |-> !core_clk_en && !bus_clk_en && !irq_ctrl_clk_en && !snoop_en)
    else $error("clocks left running in sleep");
  a_sync_delay: assert property (
    $fell(stop_clock_req_n) ##1 !stop_clock_req_n[*2] |=> !stp_s_n)
    else $error("synchroniser latency wrong");

  c_tristate:   cover property ($rose(outputs_tristate));
  c_smm_entry:  cover property ($rose(handler_fetch));
  c_stop_grant: cover property (state_ff.st == ST_STPGNT);
  c_sleep:      cover property ($rose(pll_only));
  c_resume:     cover property ($rose(core_clk_en));

endmodule
`default_nettype wire

// >>> sim/sideband_core_model.sv
// core and bus unit stand-in: answers state save and acknowledge requests
// assumes: dly set by the bench, at least 1, changed only between requests
`timescale 1ns/100ps
`default_nettype none
module sideband_core_model
(
  // clock
  input  wire logic       core_clk,
  // requests from the block
  input  wire logic       save_req,
  input  wire logic       ack_req,
  input  wire logic [3:0] dly,
  // answers
  output var  logic       save_done,
  output var  logic       ack_done
);
  initial
  begin
    save_done = 1'b0;
    ack_done  = 1'b0;
  end
  // state save finishes after dly cycles
  always
  begin
    @(negedge core_clk);
    if (save_req === 1'b1)
    begin
      repeat (dly) @(negedge core_clk);
      save_done = 1'b1;
      @(negedge core_clk);
      save_done = 1'b0;
      wait (save_req !== 1'b1);
    end
  end
  // bus transaction completes after dly cycles
  always
  begin
    @(negedge core_clk);
    if (ack_req === 1'b1)
    begin
      repeat (dly) @(negedge core_clk);
      ack_done = 1'b1;
      @(negedge core_clk);
      ack_done = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/smm_entry_and_stop_grant_control_test.sv
// testbench: reset strap, mode entry and stop-grant / sleep
// assumes: core model answers handshakes; pins driven at falling edge
`timescale 1ns/100ps
`default_nettype none
module smm_entry_and_stop_grant_control_test;
  import smm_stop_clock_req_n_pkg::*;
  logic core_clk = 0, rstn = 0, irq_n = 1, stp_n = 1, slp_n = 1, rsm_exit = 0;
  logic save_done, ack_done, save_req, mode, fetch, tri_st, ack_req;
  logic core_en, bus_en, irq_en, snoop_en, pll_only;
  logic [1:0] ack_code;
  logic [3:0] dly = 4'h1;
  logic [1:0] exp_q[$];
  int seed = 96071, n_errors = 0, num_checks = 0, n_fetch = 0, t;
  always #2 core_clk = ~core_clk;
  smm_stop_clock_req_n_ctl u_smm_stop_clock_req_n_ctl (.core_clk(core_clk), .rstn(rstn), .sys_mgmt_irq_n(irq_n),
    .stop_clock_req_n(stp_n), .sleep_req_n(slp_n), .save_done(save_done), .rsm_exit(rsm_exit),
    .ack_done(ack_done), .save_req(save_req), .sys_mgmt_mode(mode), .handler_fetch(fetch),
    .outputs_tristate(tri_st), .ack_req(ack_req), .ack_code(ack_code), .core_clk_en(core_en),
    .bus_clk_en(bus_en), .irq_ctrl_clk_en(irq_en), .snoop_en(snoop_en), .pll_only(pll_only));
  sideband_core_model u_sideband_core_model (.core_clk(core_clk), .save_req(save_req),
    .ack_req(ack_req), .dly(dly), .save_done(save_done), .ack_done(ack_done));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic c, input string m);
    num_checks++;
    if (c !== 1'b1)
    begin
      n_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task do_reset(input logic irq);
    rstn  = 1'b0;
    irq_n = irq;
    cyc(3);
    rstn  = 1'b1;
  endtask
  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // monitor and watchdog
  // ----------------------------------------
  always @(negedge core_clk)
  begin
    if (fetch === 1'b1)
      n_fetch++;
    if (ack_req === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(1'b0, "unexpected acknowledge");
      else
        chk(ack_code === exp_q.pop_front(), "acknowledge code");
    end
  end
  initial
  begin
    #20000;
    chk(1'b0, "timeout");
    close_out;
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    do_reset(1'b0);
    cyc(3);
    chk(tri_st === 1'b1, "no tristate after strap");
    do_reset(1'b1);
    cyc(3);
    chk(tri_st === 1'b0, "tristate without strap");
    $display("done: reset strap");
    for (t = 0; t < 2; t++)
    begin
      dly = 4'h1 + 4'({$random(seed)} % 4);
      exp_q.push_back(ACK_SMM);
      irq_n = 1'b0;
      cyc(4);
      chk(save_req === 1'b1, "no state save");
      cyc(20);
      irq_n = 1'b1;
      chk(mode === 1'b1 && n_fetch == t + 1, "mode entry or fetch");
      rsm_exit = 1'b1;
      cyc(1);
      rsm_exit = 1'b0;
      cyc(2);
      chk(mode === 1'b0, "mode not left");
    end
    $display("done: management mode");
    slp_n = 1'b0;
    cyc(5);
    chk(pll_only === 1'b0 && core_en === 1'b1, "sleep outside stop-grant");
    slp_n = 1'b1;
    exp_q.push_back(ACK_STPGNT);
    stp_n = 1'b0;
    cyc(20);
    chk(core_en === 1'b0 && bus_en === 1'b1 && irq_en === 1'b1, "stop-grant gating");
    chk(snoop_en === 1'b1, "snoop stopped");
    slp_n = 1'b0;
    cyc(5);
    chk(pll_only === 1'b1 && bus_en === 1'b0 && snoop_en === 1'b0, "sleep entry");
    slp_n = 1'b1;
    cyc(5);
    chk(pll_only === 1'b0 && bus_en === 1'b1 && core_en === 1'b0, "sleep exit");
    stp_n = 1'b1;
    cyc(5);
    chk(core_en === 1'b1, "clocks not restarted");
    chk(exp_q.size() == 0, "acknowledge missing");
    $display("done: stop-grant and sleep");
    close_out;
  end
endmodule
`default_nettype wire
